// file: rtl/sbl_loader.sv
`timescale 1ns/100ps
module sbl_loader import sbl_pkg::*; #(
   parameter int AW = 16,
   parameter logic [23:0] MEM_SIZE = 24'h010000
) (
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire sbl_rx_s I_RX,
   input wire logic I_TX_READY,
   input wire logic I_PWD_BLANK,
   input wire logic I_SECURITY_ON,
   output sbl_tx_s O_TX,
   output logic O_JUMP,
   output logic [23:0] O_JUMP_ADDR,
   output logic O_IDLE
);
   sbl_state_e state_ff;
   sbl_tx_s tx_ff;
   logic [8:0] idx_ff;
   logic [23:0] pw_cnt_addr_ff, pw_cmp_addr_ff, rd_addr_ff, rd_cnt_ff, jump_addr_ff;
   logic [7:0] pw_len_ff, cmd_ff, err_code_ff, rec_len_ff, rec_type_ff, rec_sum_ff;
   logic [15:0] rec_addr_ff, sum_ff;
   logic [1:0] err_rep_ff;
   logic first_ff, jump_ff, idle_ff;
   logic rx_ok, rx_bad, send_en, mem_we;
   logic [7:0] send_byte, mem_rdata;
   logic [AW-1:0] mem_addr;
   logic [15:0] rec_tgt;
   logic [8:0] rec_ck_idx;

   function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [7:0] b);
      return {v[15:0], b};
   endfunction : shift_in

   assign rx_ok = I_RX.valid && !I_RX.err;
   assign rx_bad = I_RX.valid && I_RX.err;
   assign rec_tgt = rec_addr_ff + 16'(idx_ff - REC_HDR);
   assign rec_ck_idx = 9'(rec_len_ff) + REC_HDR;
   assign mem_we = (state_ff == S_REC) && rx_ok && (idx_ff >= REC_HDR)
      && (idx_ff < rec_ck_idx) && (rec_type_ff == REC_DATA);

   // ----------------------------------------
   // Memory port
   // ----------------------------------------
   always_comb begin
      case (state_ff)
         S_PWLEN: mem_addr = pw_cnt_addr_ff[AW-1:0];
         S_PWSTR: mem_addr = AW'(pw_cmp_addr_ff + 24'(idx_ff));
         S_REC: mem_addr = rec_tgt[AW-1:0];
         default: mem_addr = rd_addr_ff[AW-1:0];
      endcase
   end

   sbl_ram #(.AW(AW), .DW(8)) u_ram (
      .i_clk(I_CLOCK),
      .i_we(mem_we),
      .i_addr(mem_addr),
      .i_wdata(I_RX.data),
      .o_rdata(mem_rdata)
   );

   // ----------------------------------------
   // Transmit requests
   // ----------------------------------------
   // Echo states load the transmitter unconditionally: the host waits for the
   // previous answer before sending, so the transmitter is free by then.
   always_comb begin
      send_en = 1'b0;
      send_byte = I_RX.data;
      case (state_ff)
         S_SYNC1: send_en = rx_ok && (I_RX.data == MATCH1_A || I_RX.data == MATCH1_B);
         S_SYNC2: send_en = rx_ok && (I_RX.data == MATCH2_A || I_RX.data == MATCH2_B);
         S_CMD: send_en = rx_ok && !I_SECURITY_ON
            && (I_RX.data == CMD_READ || I_RX.data == CMD_LOAD);
         S_ERR: begin
            send_en = !tx_ff.valid;
            send_byte = err_code_ff;
         end
         S_RSEND: begin
            send_en = !tx_ff.valid;
            send_byte = mem_rdata;
         end
         S_SUMHI: begin
            send_en = !tx_ff.valid;
            send_byte = sum_ff[15:8];
         end
         S_SUMLO: begin
            send_en = !tx_ff.valid;
            send_byte = sum_ff[7:0];
         end
         default: send_en = 1'b0;
      endcase
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         tx_ff <= '0;
      end else if (send_en) begin
         tx_ff.valid <= 1'b1;
         tx_ff.data <= send_byte;
      end else if (I_TX_READY) begin
         tx_ff.valid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Command sequencer
   // ----------------------------------------
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         state_ff <= S_SYNC1;
         idx_ff <= '0;
         err_rep_ff <= '0;
         err_code_ff <= ERR_RX;
         cmd_ff <= CMD_READ;
         pw_len_ff <= '0;
      end else begin
         case (state_ff)
            S_SYNC1: if (send_en) state_ff <= S_SYNC2; // Failed detection: stay silent
            S_SYNC2: begin
               if (send_en) begin
                  state_ff <= S_CMD;
               end else if (I_RX.valid) begin
                  state_ff <= S_IDLE;
               end
            end
            S_CMD: begin
               idx_ff <= '0;
               err_rep_ff <= '0;
               if (send_en) begin
                  cmd_ff <= I_RX.data;
                  state_ff <= S_PADDR;
               end else if (I_RX.valid) begin
                  state_ff <= S_ERR;
                  err_code_ff <= I_RX.err ? ERR_RX : (I_SECURITY_ON ? ERR_SEC : ERR_CMD);
               end
            end
            S_ERR: begin
               if (send_en) begin
                  err_rep_ff <= err_rep_ff + 2'h1;
                  if (err_rep_ff == ERR_REPEAT - 2'h1) state_ff <= S_IDLE;
               end
            end
            S_PADDR: begin
               if (rx_bad) begin
                  state_ff <= S_IDLE;
               end else if (rx_ok) begin
                  idx_ff <= (idx_ff == FIELD_LAST) ? '0 : idx_ff + 9'h001;
                  if (idx_ff == FIELD_LAST) state_ff <= S_PWCHK;
               end
            end
            S_PWCHK: begin
               if (pw_cnt_addr_ff >= MEM_SIZE || pw_cmp_addr_ff >= MEM_SIZE) begin
                  state_ff <= S_IDLE;
               end else if (I_PWD_BLANK) begin
                  state_ff <= (cmd_ff == CMD_READ) ? S_FIELD : S_REC;
               end else begin
                  state_ff <= S_PWLEN;
               end
            end
            S_PWLEN: begin
               // Second cycle: registered read of the length byte has landed
               idx_ff <= (idx_ff == '0) ? 9'h001 : '0;
               if (idx_ff != '0) begin
                  pw_len_ff <= mem_rdata;
                  if (mem_rdata == '0) state_ff <= S_IDLE;
                  else state_ff <= S_PWSTR;
               end
            end
            S_PWSTR: begin
               if (rx_bad || (rx_ok && I_RX.data != mem_rdata)) begin
                  state_ff <= S_IDLE;
               end else if (rx_ok) begin
                  idx_ff <= (idx_ff == 9'(pw_len_ff) - 9'h001) ? '0 : idx_ff + 9'h001;
                  if (idx_ff == 9'(pw_len_ff) - 9'h001) begin
                     state_ff <= (cmd_ff == CMD_READ) ? S_FIELD : S_REC;
                  end
               end
            end
            S_FIELD: begin
               if (I_RX.valid) begin
                  idx_ff <= (idx_ff == FIELD_LAST) ? '0 : idx_ff + 9'h001;
                  if (idx_ff == FIELD_LAST) state_ff <= S_RCHK;
               end
            end
            S_RCHK: begin
               if (rd_cnt_ff == '0 || rd_cnt_ff > MEM_SIZE) state_ff <= S_IDLE;
               else state_ff <= S_RFETCH;
            end
            S_RFETCH: state_ff <= S_RSEND;
            S_RSEND: if (send_en) state_ff <= (rd_cnt_ff == 24'h000001) ? S_SUMHI : S_RFETCH;
            S_SUMHI: if (send_en) state_ff <= S_SUMLO;
            S_SUMLO: if (send_en) state_ff <= (cmd_ff == CMD_READ) ? S_CMD : S_JUMP;
            S_REC: begin
               if (rx_bad) begin
                  state_ff <= S_IDLE;
               end else if (rx_ok) begin
                  idx_ff <= idx_ff + 9'h001;
                  if (idx_ff >= REC_HDR && idx_ff == rec_ck_idx) begin
                     idx_ff <= '0;
                     // Bad record checksum ends the session with no answer
                     if (8'(rec_sum_ff + I_RX.data) != 8'h00) state_ff <= S_IDLE;
                     else if (rec_type_ff == REC_END) state_ff <= S_SUMHI;
                  end
               end
            end
            S_JUMP: state_ff <= S_JUMP;
            S_IDLE: state_ff <= S_IDLE;
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Address, count and record fields
   // ----------------------------------------
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         pw_cnt_addr_ff <= '0;
         pw_cmp_addr_ff <= '0;
         rd_addr_ff <= '0;
         rd_cnt_ff <= '0;
         rec_len_ff <= '0;
         rec_addr_ff <= '0;
         rec_type_ff <= '0;
         rec_sum_ff <= '0;
      end else begin
         if (state_ff == S_PADDR && rx_ok) begin
            if (idx_ff < FIELD_SPLIT) pw_cnt_addr_ff <= shift_in(pw_cnt_addr_ff, I_RX.data);
            else pw_cmp_addr_ff <= shift_in(pw_cmp_addr_ff, I_RX.data);
         end
         if (state_ff == S_FIELD && I_RX.valid) begin
            if (idx_ff < FIELD_SPLIT) rd_addr_ff <= shift_in(rd_addr_ff, I_RX.data);
            else rd_cnt_ff <= shift_in(rd_cnt_ff, I_RX.data);
         end
         if (state_ff == S_RSEND && send_en) begin
            rd_addr_ff <= rd_addr_ff + 24'h000001;
            rd_cnt_ff <= rd_cnt_ff - 24'h000001;
         end
         if (state_ff == S_REC && rx_ok) begin
            rec_sum_ff <= (idx_ff == '0) ? I_RX.data : rec_sum_ff + I_RX.data;
            case (idx_ff)
               9'h000: rec_len_ff <= I_RX.data;
               9'h001: rec_addr_ff[15:8] <= I_RX.data;
               9'h002: rec_addr_ff[7:0] <= I_RX.data;
               9'h003: rec_type_ff <= I_RX.data;
               default: rec_type_ff <= rec_type_ff;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Checksum and jump target
   // ----------------------------------------
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         sum_ff <= SUM_RESET;
         first_ff <= 1'b1;
         jump_addr_ff <= JUMP_RESET;
      end else begin
         if (state_ff == S_CMD) begin
            sum_ff <= SUM_RESET;
            first_ff <= 1'b1;
         end else if (state_ff == S_RSEND && send_en) begin
            sum_ff <= sum_ff + 16'(mem_rdata);
         end else if (mem_we) begin
            sum_ff <= sum_ff + 16'(I_RX.data);
            first_ff <= 1'b0;
            if (first_ff) jump_addr_ff <= 24'(rec_tgt);
         end
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         jump_ff <= 1'b0;
         idle_ff <= 1'b0;
      end else begin
         jump_ff <= (state_ff == S_JUMP);
         idle_ff <= (state_ff == S_IDLE);
      end
   end

   assign O_TX = tx_ff;
   assign O_JUMP = jump_ff;
   assign O_JUMP_ADDR = jump_addr_ff;
   assign O_IDLE = idle_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [2:0] err_tx_cnt_ff;
   always_ff @(posedge I_CLOCK) begin
      if (I_RST || state_ff == S_CMD) err_tx_cnt_ff <= '0;
      else if (state_ff == S_ERR && send_en) err_tx_cnt_ff <= err_tx_cnt_ff + 3'h1;
   end

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);

   a_match1_echo: assert property (state_ff == S_SYNC1 && rx_ok && I_RX.data == MATCH1_B
      |=> O_TX.valid && O_TX.data == MATCH1_B && state_ff == S_SYNC2)
      else $error("first match byte not echoed");
   a_match2_fail: assert property (state_ff == S_SYNC2 && I_RX.valid && !send_en
      |=> state_ff == S_IDLE ##1 O_IDLE)
      else $error("bad second match byte not idled");
   a_cmd_echo: assert property (state_ff == S_CMD && rx_ok && I_RX.data == CMD_READ
      && !I_SECURITY_ON |=> O_TX.valid && O_TX.data == CMD_READ)
      else $error("read command not echoed");
   a_err_three: assert property ($past(state_ff) == S_ERR && state_ff == S_IDLE
      |-> err_tx_cnt_ff == 3'h3)
      else $error("error code not sent three times");
   a_security_err: assert property (state_ff == S_CMD && rx_ok && I_SECURITY_ON
      |=> state_ff == S_ERR && err_code_ff == ERR_SEC)
      else $error("security not refused");
   a_count_range: assert property (state_ff == S_RCHK && rd_cnt_ff == '0
      |=> state_ff == S_IDLE)
      else $error("zero count accepted");
   a_pw_addr_bad: assert property (state_ff == S_PWCHK && pw_cmp_addr_ff >= MEM_SIZE
      |=> state_ff == S_IDLE)
      else $error("bad password address accepted");
   a_pw_link_err: assert property ((state_ff == S_PADDR || state_ff == S_PWSTR) && rx_bad
      |=> state_ff == S_IDLE)
      else $error("link error in password phase not idled");
   a_blank_skip: assert property (state_ff == S_PWCHK && I_PWD_BLANK && pw_cnt_addr_ff < MEM_SIZE
      && pw_cmp_addr_ff < MEM_SIZE |=> state_ff == S_FIELD || state_ff == S_REC)
      else $error("blank part not skipping password");
   a_read_data: assert property (state_ff == S_RSEND && send_en
      |=> O_TX.data == $past(mem_rdata) && O_TX.valid)
      else $error("read data byte wrong");
   a_sum_order: assert property (state_ff == S_SUMHI && send_en
      |=> O_TX.data == $past(sum_ff[15:8]) ##[1:1000] state_ff != S_SUMLO)
      else $error("checksum order wrong");
   a_read_return: assert property (state_ff == S_SUMLO && send_en && cmd_ff == CMD_READ
      |=> state_ff == S_CMD)
      else $error("read did not return to command wait");
   a_jump_out: assert property (state_ff == S_JUMP |=> O_JUMP ##1 O_JUMP)
      else $error("jump not signalled");

   c_read_done: cover property (state_ff == S_SUMLO && send_en && cmd_ff == CMD_READ);
   c_loader_jump: cover property (state_ff == S_JUMP && !O_JUMP);
   c_err_idle: cover property (state_ff == S_ERR ##1 state_ff == S_IDLE);
   c_pw_checked: cover property (state_ff == S_PWSTR ##1 state_ff == S_FIELD);
endmodule : sbl_loader

// file: rtl/sbl_pkg.sv
package sbl_pkg;
   // ----------------------------------------
   // Link byte values
   // ----------------------------------------
   localparam logic [7:0] MATCH1_A = 8'h86;
   localparam logic [7:0] MATCH1_B = 8'h30;
   localparam logic [7:0] MATCH2_A = 8'h79;
   localparam logic [7:0] MATCH2_B = 8'hCF;
   localparam logic [7:0] CMD_READ = 8'h40;
   localparam logic [7:0] CMD_LOAD = 8'h60;
   localparam logic [7:0] ERR_RX = 8'hA1;
   localparam logic [7:0] ERR_CMD = 8'hA3;
   localparam logic [7:0] ERR_SEC = 8'h63;
   localparam logic [1:0] ERR_REPEAT = 2'h3;
   localparam logic [7:0] REC_DATA = 8'h00;
   localparam logic [7:0] REC_END = 8'h01;
   // ----------------------------------------
   // Field layout of a three byte field pair and a record header
   // ----------------------------------------
   localparam logic [8:0] FIELD_LAST = 9'h005;
   localparam logic [8:0] FIELD_SPLIT = 9'h003;
   localparam logic [8:0] REC_HDR = 9'h004;
   localparam logic [15:0] SUM_RESET = 16'h0000;
   localparam logic [23:0] JUMP_RESET = 24'h000000;

   typedef enum logic [4:0] {
      S_SYNC1 = 5'b00000, S_SYNC2 = 5'b00001, S_CMD = 5'b00010, S_ERR = 5'b00011,
      S_PADDR = 5'b00100, S_PWCHK = 5'b00101, S_PWLEN = 5'b00110, S_PWSTR = 5'b00111,
      S_FIELD = 5'b01000, S_RCHK = 5'b01001, S_RFETCH = 5'b01010, S_RSEND = 5'b01011,
      S_SUMHI = 5'b01100, S_SUMLO = 5'b01101, S_REC = 5'b01110, S_JUMP = 5'b01111,
      S_IDLE = 5'b10000
   } sbl_state_e;

   typedef struct packed {
      logic valid;
      logic err;
      logic [7:0] data;
   } sbl_rx_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sbl_tx_s;
endpackage : sbl_pkg

// file: rtl/sbl_ram.sv
`timescale 1ns/100ps
module sbl_ram #(
   parameter int AW = 16,
   parameter int DW = 8
) (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_addr,
   input wire logic [DW-1:0] i_wdata,
   output logic [DW-1:0] o_rdata
);
   logic [DW-1:0] mem [0:(2**AW)-1];

   // Read data registered; a write returns the old word
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule : sbl_ram

// file: dv/sbl_host_model.sv
`timescale 1ns/100ps
module sbl_host_model import sbl_pkg::*; (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire sbl_tx_s i_tx,
   output sbl_rx_s o_rx,
   output logic o_tx_ready
);
   logic [7:0] got_q[$];

   initial begin
      o_rx = '0;
      o_tx_ready = 1'b0;
   end

   // A slow host stalls at random so that held answers get exercised
   always @(posedge i_clk) begin
      if (i_tx.valid && o_tx_ready) begin
         got_q.push_back(i_tx.data);
      end
      o_tx_ready <= i_slow ? 1'($urandom_range(0, 1)) : 1'b1;
   end

   // Idle data is inverted so a stale byte never looks like a fresh one
   task automatic send(input logic [7:0] d, input logic e);
      o_rx <= '{valid: 1'b1, err: e, data: d};
      @(posedge i_clk);
      o_rx <= '{valid: 1'b0, err: 1'b0, data: ~d};
      repeat (3) @(posedge i_clk);
   endtask : send

   task automatic send24(input logic [23:0] v);
      send(v[23:16], 1'b0);
      send(v[15:8], 1'b0);
      send(v[7:0], 1'b0);
   endtask : send24
endmodule : sbl_host_model

// file: dv/sbl_loader_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module sbl_loader_tb import sbl_pkg::*;;
   localparam logic [23:0] MEM = 24'h010000;
   localparam int LIMIT = 20000;
   logic clk;
   logic rst;
   logic blank;
   logic sec;
   logic slow;
   sbl_rx_s rx;
   logic rdy;
   sbl_tx_s tx;
   logic jump;
   logic idle;
   logic [23:0] jaddr;
   logic [7:0] mem [logic [15:0]];
   logic [15:0] base;
   int n;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] bad_cmd [3] = '{8'h55, CMD_READ, CMD_LOAD};
   logic bad_err [3] = '{1'b0, 1'b1, 1'b0};
   logic bad_sec [3] = '{1'b0, 1'b0, 1'b1};
   logic [7:0] bad_code [3] = '{ERR_CMD, ERR_RX, ERR_SEC};

   sbl_loader #(.MEM_SIZE(MEM)) dut (
      .I_CLOCK(clk), .I_RST(rst), .I_RX(rx), .I_TX_READY(rdy), .I_PWD_BLANK(blank),
      .I_SECURITY_ON(sec), .O_TX(tx), .O_JUMP(jump), .O_JUMP_ADDR(jaddr), .O_IDLE(idle)
   );
   sbl_host_model host (.i_clk(clk), .i_slow(slow), .i_tx(tx), .o_rx(rx), .o_tx_ready(rdy));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // Link tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task automatic do_reset();
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      host.got_q.delete();
   endtask : do_reset

   task automatic get_rx(output logic [7:0] g);
      int t;
      t = 0;
      while (host.got_q.size() == 0 && t < 3000) begin
         @(posedge clk);
         t++;
      end
      g = 'x;
      if (host.got_q.size() > 0) begin
         g = host.got_q.pop_front();
      end
   endtask : get_rx

   // Idle must hold: a later command gets no answer at all
   task automatic chk_idle();
      int t;
      for (t = 0; t < 50 && idle !== 1'b1; t++) begin
         @(posedge clk);
      end
      `CHK(idle, 1'b1)
      host.send(CMD_READ, 1'b0);
      repeat (10) @(posedge clk);
      `CHK(host.got_q.size(), 0)
   endtask : chk_idle

   task automatic boot(input logic [7:0] m1, input logic [7:0] m2);
      logic [7:0] g;
      host.send(m1, 1'b0);
      get_rx(g);
      `CHK(g, m1)
      host.send(m2, 1'b0);
      get_rx(g);
      `CHK(g, m2)
   endtask : boot

   // Stored length at base is 2, so the string is the two bytes after it
   task automatic pw_phase(input logic good);
      if (blank === 1'b1) begin
         host.send24(24'h00FFE0);
         host.send24(24'h00FFE1);
      end else begin
         host.send24({8'h00, base});
         host.send24({8'h00, base + 16'h0001});
         // The device fetches the stored length first, so give it time to compare
         repeat (2) @(posedge clk);
         host.send(mem[base + 16'h0001], 1'b0);
         host.send(mem[base + 16'h0002] ^ {7'h00, !good}, 1'b0);
      end
   endtask : pw_phase

   task automatic read_head(input logic good);
      logic [7:0] g;
      host.send(CMD_READ, 1'b0);
      get_rx(g);
      `CHK(g, CMD_READ)
      pw_phase(good);
   endtask : read_head

   task automatic read_body(input logic [15:0] a, input int cnt);
      logic [7:0] g;
      logic [15:0] sum;
      int i;
      sum = 16'h0000;
      for (i = 0; i < cnt; i++) begin
         get_rx(g);
         `CHK(g, mem[a + 16'(i)])
         sum = sum + {8'h00, mem[a + 16'(i)]};
      end
      get_rx(g);
      `CHK(g, sum[15:8])
      get_rx(g);
      `CHK(g, sum[7:0])
   endtask : read_body

   task automatic run_loader();
      logic [7:0] g;
      logic [7:0] d;
      logic [7:0] ck;
      logic [15:0] sum;
      int i;
      base = 16'h0100 + 16'($urandom_range(0, 16'h0E00));
      n = $urandom_range(3, 8);
      sum = 16'h0000;
      host.send(CMD_LOAD, 1'b0);
      get_rx(g);
      `CHK(g, CMD_LOAD)
      pw_phase(1'b1);
      ck = 8'(n) + base[15:8] + base[7:0] + REC_DATA;
      host.send(8'(n), 1'b0);
      host.send(base[15:8], 1'b0);
      host.send(base[7:0], 1'b0);
      host.send(REC_DATA, 1'b0);
      for (i = 0; i < n; i++) begin
         d = (i == 0) ? 8'h02 : 8'($urandom);
         mem[base + 16'(i)] = d;
         sum = sum + {8'h00, d};
         ck = ck + d;
         host.send(d, 1'b0);
      end
      host.send(8'h00 - ck, 1'b0);
      `CHK(host.got_q.size(), 0)
      // End record: zero length, zero address, type end, checksum
      host.send24(24'h000000);
      host.send(REC_END, 1'b0);
      host.send(8'hFF, 1'b0);
      get_rx(g);
      `CHK(g, sum[15:8])
      get_rx(g);
      `CHK(g, sum[7:0])
      for (i = 0; i < 20 && jump !== 1'b1; i++) begin
         @(posedge clk);
      end
      `CHK(jump, 1'b1)
      `CHK(jaddr, {8'h00, base})
   endtask : run_loader

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] g;
      int k;
      rst = 1'b1;
      blank = 1'b1;
      sec = 1'b0;
      slow = 1'b0;
      void'($urandom(32'hC1F3));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      host.send(8'($urandom_range(8'h31, 8'h78)), 1'b0);
      host.send(MATCH1_A, 1'b1);
      `CHK(host.got_q.size(), 0)
      boot(MATCH1_B, MATCH2_B);
      run_loader();
      // Loaded bytes survive reset and are read back below
      do_reset();
      slow <= 1'b1;
      boot(MATCH1_A, MATCH2_A);
      read_head(1'b1);
      host.send24({8'h00, base});
      host.send24(24'(n));
      read_body(base, n);
      blank <= 1'b0;
      read_head(1'b1);
      host.send24({8'h00, base + 16'h0001});
      host.send24(24'h000002);
      read_body(base + 16'h0001, 2);
      read_head(1'b0);
      chk_idle();
      slow <= 1'($urandom_range(0, 1));
      blank <= 1'b1;
      for (k = 0; k < 2; k++) begin
         do_reset();
         boot(MATCH1_A, MATCH2_B);
         read_head(1'b1);
         host.send24({8'h00, base});
         host.send24(k == 0 ? 24'h000000 : MEM + 24'h000001);
         chk_idle();
      end
      do_reset();
      boot(MATCH1_B, MATCH2_A);
      host.send(CMD_READ, 1'b0);
      get_rx(g);
      host.send24(MEM);
      host.send24(24'h00FFE1);
      chk_idle();
      do_reset();
      boot(MATCH1_A, MATCH2_A);
      host.send(CMD_LOAD, 1'b0);
      get_rx(g);
      host.send(8'h00, 1'b1);
      chk_idle();
      do_reset();
      host.send(MATCH1_A, 1'b0);
      get_rx(g);
      host.send(8'($urandom_range(8'h00, 8'h78)), 1'b0);
      chk_idle();
      for (k = 0; k < 3; k++) begin
         do_reset();
         sec <= bad_sec[k];
         boot(MATCH1_A, MATCH2_A);
         host.send(bad_cmd[k], bad_err[k]);
         repeat (3) begin
            get_rx(g);
            `CHK(g, bad_code[k])
         end
         chk_idle();
      end
      end_of_test();
   end
endmodule : sbl_loader_tb
